// File: rtl/ctp_pkg.sv
// Package with offsets, fields, reset values and ratio codes of the clock control block
package ctp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_OSC_TRIM   = 8'h00;
   localparam logic [7:0] OFS_CLK_CFG    = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h44;

   // Oscillator trim register fields
   localparam int TRIM_LSB    = 4;
   localparam int TRIM_MSB    = 7;
   localparam int RDY48_BIT   = 1;
   localparam int RDY40_BIT   = 0;
   localparam logic [3:0] TRIM_RESET = 4'h8;

   // Clock divider configuration fields
   localparam int CLKOUT_DIV_LSB = 28;
   localparam int CLKOUT_DIV_MSB = 31;
   localparam int CLKOUT_SRC_LSB = 25;
   localparam int CLKOUT_SRC_MSB = 26;
   localparam int CORE_DIV_LSB   = 12;
   localparam int CORE_DIV_MSB   = 13;
   localparam int PER_DIV_LSB    = 8;
   localparam int PER_DIV_MSB    = 10;
   localparam int SYS_DIV_LSB    = 4;
   localparam int SYS_DIV_MSB    = 7;
   localparam logic [3:0] CLKOUT_DIV_RESET = 4'h2;
   localparam logic [1:0] CLKOUT_SRC_RESET = 2'h0;
   localparam logic [1:0] CORE_DIV_RESET   = 2'h3;
   localparam logic [2:0] PER_DIV_RESET    = 3'h0;
   localparam logic [3:0] SYS_DIV_RESET    = 4'h0;

   // Interrupt status bits
   localparam int IRQ_RDY48 = 0;
   localparam int IRQ_RDY40 = 1;
   localparam int IRQ_BITS  = 2;

   // Clock output source codes
   typedef enum logic [1:0] {
      CTP_SRC_NONE     = 2'h0,
      CTP_SRC_SLOW_INT = 2'h1,
      CTP_SRC_SLOW_EXT = 2'h2,
      CTP_SRC_ILLEGAL  = 2'h3
   } ctp_src_t;

   // Divider widths and reset-time ratios (core /6 at 48 MHz after reset)
   localparam int BUS_DIV_W    = 5;
   localparam int CLKOUT_DIV_W = 7;
   localparam logic [4:0] CORE_RATIO_RESET   = 5'h06;
   localparam logic [4:0] BUS_RATIO_RESET    = 5'h01;
   localparam logic [6:0] CLKOUT_RATIO_RESET = 7'h06;
   localparam logic [4:0] CLKOUT_DIV_MAX     = 5'h10;
   localparam logic [5:0] CLKOUT_RATIO_TOP   = 6'h20;
endpackage : ctp_pkg

// File: rtl/ctp_divider.sv
// Glitch-free ratio divider producing one tick per ratio advances
`timescale 1ns/1ps
module ctp_divider #(
   parameter int              W         = 5,
   parameter logic [W-1:0]    RST_RATIO = '0
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_arst_n,
   // Control
   input  wire logic          i_adv,
   input  wire logic [W-1:0]  i_ratio,
   // Status
   output logic      [W-1:0]  o_cnt,
   output logic      [W-1:0]  o_ratio_held,
   output logic               o_tick
);
   logic [W-1:0] cnt;
   logic [W-1:0] held;
   wire          at_end = (cnt == held - W'(1));

   // Ratio is taken only at the period boundary, so no runt period appears
   assign o_tick       = i_adv && at_end;
   assign o_cnt        = cnt;
   assign o_ratio_held = held;

   // Counter and held ratio
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt  <= '0;
         held <= RST_RATIO;
      end
      else if (o_tick)
      begin
         cnt  <= '0;
         held <= (i_ratio == '0) ? W'(1) : i_ratio;
      end
      else if (i_adv)
      begin
         cnt <= cnt + W'(1);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   AST_RATIO_AT_BOUNDARY: assert property (!o_tick |=> $stable(held))
      else $error("divider ratio changed inside a period");
   AST_COUNT_BELOW_RATIO: assert property (cnt < held)
      else $error("divider count ran past its ratio");
endmodule : ctp_divider

// File: rtl/ctp_clock_cfg.sv
// Clock trim, ready flags, prescalers and clock-output divider with Avalon-MM slave
`timescale 1ns/1ps
module ctp_clock_cfg (
   // Clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_ARST_N,
   // Avalon-MM slave
   input  wire logic [7:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   // Oscillator status and mode
   input  wire logic        I_OSC48_STABLE,
   input  wire logic        I_OSC40_STABLE,
   input  wire logic        I_OSC_IS_48,
   input  wire logic        I_STOP_EXIT,
   // Slow clock edge events, one pulse per edge
   input  wire logic        I_SLOW_INT_EDGE,
   input  wire logic        I_SLOW_EXT_EDGE,
   // Clock tree enables and clock-output pin
   output logic             O_CORE_CLK_EN,
   output logic             O_SYS_BUS_CLK_EN,
   output logic             O_PERIPH_CLK_EN,
   output logic             O_CLKOUT,
   // Interrupt
   output logic             O_IRQ
);
   // Register state
   logic [3:0]          fast_osc_trim;
   logic                fast_osc_48_ready_flag;
   logic                fast_osc_40_ready_flag;
   logic [3:0]          clkout_divider;
   logic [1:0]          clkout_source_select;
   logic [1:0]          core_clk_divider;
   logic [2:0]          periph_bus_divider;
   logic [3:0]          sys_bus_divider;
   logic [ctp_pkg::IRQ_BITS-1:0] irq_status;
   logic [ctp_pkg::IRQ_BITS-1:0] irq_mask;

   // Bus decode: a request is taken on the edge where waitrequest is low
   wire        req       = I_AVS_READ || I_AVS_WRITE;
   wire        accept    = req && !O_AVS_WAITREQUEST;
   wire        wr_go     = accept && I_AVS_WRITE;
   wire        rd_go     = accept && I_AVS_READ;
   wire        sel_trim  = (I_AVS_ADDRESS == ctp_pkg::OFS_OSC_TRIM);
   wire        sel_cfg   = (I_AVS_ADDRESS == ctp_pkg::OFS_CLK_CFG);
   wire        sel_stat  = (I_AVS_ADDRESS == ctp_pkg::OFS_IRQ_STATUS);
   wire        sel_mask  = (I_AVS_ADDRESS == ctp_pkg::OFS_IRQ_MASK);
   wire [31:0] be_mask   = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                            {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

   // Readback images; reserved bits read as zero
   wire [31:0] img_trim = {24'h00_0000, fast_osc_trim, 2'h0,
                           fast_osc_48_ready_flag, fast_osc_40_ready_flag};
   wire [31:0] img_cfg  = {clkout_divider, 1'b0, clkout_source_select, 11'h000,
                           core_clk_divider, 1'b0, periph_bus_divider, sys_bus_divider, 4'h0};
   wire [31:0] img_stat = {30'h0000_0000, irq_status};
   wire [31:0] img_mask = {30'h0000_0000, irq_mask};
   wire [31:0] next_rdata = sel_trim ? img_trim :
                            sel_cfg  ? img_cfg  :
                            sel_stat ? img_stat :
                            sel_mask ? img_mask : 32'h0000_0000;

   // Merged write images; writes touch only enabled lanes
   wire [31:0] wr_trim = (img_trim & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
   wire [31:0] wr_cfg  = (img_cfg & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
   wire [31:0] wr_mask = (img_mask & ~be_mask) | (I_AVS_WRITEDATA & be_mask);

   // One wait state per request; readdata is ready at the accepting edge
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         O_AVS_WAITREQUEST <= 1'b1;
         O_AVS_READDATA    <= 32'h0000_0000;
      end
      else
      begin
         O_AVS_WAITREQUEST <= !(req && O_AVS_WAITREQUEST);
         O_AVS_READDATA    <= (I_AVS_READ && O_AVS_WAITREQUEST) ? next_rdata : 32'h0000_0000;
      end
   end

   // Trim field, software written
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         fast_osc_trim <= ctp_pkg::TRIM_RESET;
      else if (wr_go && sel_trim)
         fast_osc_trim <= wr_trim[ctp_pkg::TRIM_MSB:ctp_pkg::TRIM_LSB];
   end

   // Ready flags follow the oscillators; software writes have no effect
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         fast_osc_48_ready_flag <= 1'b0;
         fast_osc_40_ready_flag <= 1'b0;
      end
      else
      begin
         fast_osc_48_ready_flag <= I_OSC48_STABLE;
         fast_osc_40_ready_flag <= I_OSC40_STABLE;
      end
   end

   // Configuration fields; for the core field, stop exit wins over a write in the same cycle
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         clkout_divider       <= ctp_pkg::CLKOUT_DIV_RESET;
         clkout_source_select <= ctp_pkg::CLKOUT_SRC_RESET;
         core_clk_divider     <= ctp_pkg::CORE_DIV_RESET;
         periph_bus_divider   <= ctp_pkg::PER_DIV_RESET;
         sys_bus_divider      <= ctp_pkg::SYS_DIV_RESET;
      end
      else
      begin
         if (wr_go && sel_cfg)
         begin
            clkout_divider       <= wr_cfg[ctp_pkg::CLKOUT_DIV_MSB:ctp_pkg::CLKOUT_DIV_LSB];
            clkout_source_select <= wr_cfg[ctp_pkg::CLKOUT_SRC_MSB:ctp_pkg::CLKOUT_SRC_LSB];
            periph_bus_divider   <= wr_cfg[ctp_pkg::PER_DIV_MSB:ctp_pkg::PER_DIV_LSB];
            sys_bus_divider      <= wr_cfg[ctp_pkg::SYS_DIV_MSB:ctp_pkg::SYS_DIV_LSB];
         end
         if (I_STOP_EXIT)
            core_clk_divider <= ctp_pkg::CORE_DIV_RESET;
         else if (wr_go && sel_cfg)
            core_clk_divider <= wr_cfg[ctp_pkg::CORE_DIV_MSB:ctp_pkg::CORE_DIV_LSB];
      end
   end

   // Core ratio depends on which oscillator variant runs
   wire [4:0] core_ratio =
      I_OSC_IS_48 ? ((core_clk_divider == 2'h0) ? 5'h01 :
                     (core_clk_divider == 2'h1) ? 5'h02 : 5'h06) :
                    ((core_clk_divider == 2'h0) ? 5'h01 : 5'h05);

   // System bus ratio from core clock
   wire [4:0] sys_ratio =
      !sys_bus_divider[3]      ? 5'h01 :
      (sys_bus_divider == 4'h8) ? 5'h02 :
      (sys_bus_divider == 4'h9) ? 5'h04 :
      (sys_bus_divider == 4'hA) ? 5'h08 :
      (sys_bus_divider == 4'hB) ? 5'h0C :
      (sys_bus_divider == 4'hC) ? 5'h10 : 5'h18;

   // Peripheral bus ratio from system bus clock
   wire [4:0] per_ratio =
      !periph_bus_divider[2]      ? 5'h01 :
      (periph_bus_divider == 3'h4) ? 5'h02 :
      (periph_bus_divider == 3'h5) ? 5'h04 :
      (periph_bus_divider == 3'h6) ? 5'h08 : 5'h10;

   // Clock-output divide factor; code 15 divides by 32, every other code by code plus one
   wire [5:0] out_div  = (clkout_divider == 4'hF) ? ctp_pkg::CLKOUT_RATIO_TOP :
                         {2'b00, clkout_divider} + 6'h01;
   ctp_pkg::ctp_src_t out_src;
   assign out_src = ctp_pkg::ctp_src_t'(clkout_source_select);

   // Sources are edge streams; a period of the slow clock is two edges
   wire       src_none = (out_src == ctp_pkg::CTP_SRC_NONE) ||
                         (out_src == ctp_pkg::CTP_SRC_ILLEGAL);
   wire       out_adv  = (out_src == ctp_pkg::CTP_SRC_SLOW_INT) ? I_SLOW_INT_EDGE :
                         (out_src == ctp_pkg::CTP_SRC_SLOW_EXT) ? I_SLOW_EXT_EDGE : 1'b0;
   wire [6:0] out_ratio = {out_div, 1'b0};

   // Divider chain: core, then system bus, then peripheral bus
   wire       core_tick;
   wire       sys_tick;
   wire       per_tick;
   wire [4:0] core_held;
   wire [4:0] sys_held;
   wire [4:0] per_held;
   wire [6:0] out_cnt;
   wire [6:0] out_held;

   ctp_divider #(.W(ctp_pkg::BUS_DIV_W), .RST_RATIO(ctp_pkg::CORE_RATIO_RESET)) u_core_div (
      .i_clk        (I_CLK),
      .i_arst_n     (I_ARST_N),
      .i_adv        (1'b1),
      .i_ratio      (core_ratio),
      .o_cnt        (),
      .o_ratio_held (core_held),
      .o_tick       (core_tick)
   );

   ctp_divider #(.W(ctp_pkg::BUS_DIV_W), .RST_RATIO(ctp_pkg::BUS_RATIO_RESET)) u_sys_div (
      .i_clk        (I_CLK),
      .i_arst_n     (I_ARST_N),
      .i_adv        (core_tick),
      .i_ratio      (sys_ratio),
      .o_cnt        (),
      .o_ratio_held (sys_held),
      .o_tick       (sys_tick)
   );

   ctp_divider #(.W(ctp_pkg::BUS_DIV_W), .RST_RATIO(ctp_pkg::BUS_RATIO_RESET)) u_per_div (
      .i_clk        (I_CLK),
      .i_arst_n     (I_ARST_N),
      .i_adv        (sys_tick),
      .i_ratio      (per_ratio),
      .o_cnt        (),
      .o_ratio_held (per_held),
      .o_tick       (per_tick)
   );

   // Output divider; a source switch lets the running period finish, so a short pulse may appear
   ctp_divider #(.W(ctp_pkg::CLKOUT_DIV_W), .RST_RATIO(ctp_pkg::CLKOUT_RATIO_RESET)) u_out_div (
      .i_clk        (I_CLK),
      .i_arst_n     (I_ARST_N),
      .i_adv        (out_adv),
      .i_ratio      (out_ratio),
      .o_cnt        (out_cnt),
      .o_ratio_held (out_held),
      .o_tick       ()
   );

   // Pin high for the first half of each output period
   wire next_clkout = !src_none && (out_cnt < {1'b0, out_held[6:1]});

   // Interrupt events: ready flag rising edges
   wire [ctp_pkg::IRQ_BITS-1:0] irq_event;
   assign irq_event[ctp_pkg::IRQ_RDY48] = I_OSC48_STABLE && !fast_osc_48_ready_flag;
   assign irq_event[ctp_pkg::IRQ_RDY40] = I_OSC40_STABLE && !fast_osc_40_ready_flag;
   wire stat_clr = rd_go && sel_stat;
   // Only bits already reported are cleared, so an event landing in the wait state is kept
   wire [ctp_pkg::IRQ_BITS-1:0] stat_seen   = stat_clr ? O_AVS_READDATA[ctp_pkg::IRQ_BITS-1:0] : '0;
   wire [ctp_pkg::IRQ_BITS-1:0] next_status = (irq_status & ~stat_seen) | irq_event;

   // Sticky status, read clears, a new event in the clearing cycle survives
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         irq_status <= '0;
         irq_mask   <= '0;
         O_IRQ      <= 1'b0;
      end
      else
      begin
         irq_status <= next_status;
         if (wr_go && sel_mask)
            irq_mask <= wr_mask[ctp_pkg::IRQ_BITS-1:0];
         O_IRQ <= |(next_status & ((wr_go && sel_mask) ? wr_mask[ctp_pkg::IRQ_BITS-1:0] : irq_mask));
      end
   end

   // Registered clock tree enables and pin
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         O_CORE_CLK_EN    <= 1'b0;
         O_SYS_BUS_CLK_EN <= 1'b0;
         O_PERIPH_CLK_EN  <= 1'b0;
         O_CLKOUT         <= 1'b0;
      end
      else
      begin
         O_CORE_CLK_EN    <= core_tick;
         O_SYS_BUS_CLK_EN <= sys_tick;
         O_PERIPH_CLK_EN  <= per_tick;
         O_CLKOUT         <= next_clkout;
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);

   AST_TRIM_WRITE: assert property (wr_go && sel_trim && I_AVS_BYTEENABLE[0]
         |=> fast_osc_trim == $past(I_AVS_WRITEDATA[7:4]))
      else $error("trim field did not take the written value");
   AST_READY48_READ: assert property (rd_go && sel_trim
         |-> O_AVS_READDATA[1] == $past(fast_osc_48_ready_flag))
      else $error("48 MHz ready flag misread");
   AST_READY40_FOLLOW: assert property (fast_osc_40_ready_flag == $past(I_OSC40_STABLE))
      else $error("40 MHz ready flag does not follow oscillator");
   AST_CLKOUT_CODE0: assert property (clkout_divider == 4'h0 |-> out_ratio == 7'h02)
      else $error("code zero output ratio wrong");
   AST_CLKOUT_CODE_MID: assert property (clkout_divider == 4'h7 |-> out_ratio == 7'h10)
      else $error("code seven output ratio wrong");
   AST_CLKOUT_CODE15: assert property (clkout_divider == 4'hF |-> out_ratio == 7'h40)
      else $error("code fifteen output ratio wrong");
   AST_CLKOUT_NONE: assert property (src_none |=> !O_CLKOUT)
      else $error("clock output runs with no source");
   AST_CORE48_DIV6: assert property (I_OSC_IS_48 && core_clk_divider[1] |-> core_ratio == 5'h06)
      else $error("48 MHz core ratio wrong");
   AST_CORE40_DIV5: assert property (!I_OSC_IS_48 && core_clk_divider != 2'h0 |-> core_ratio == 5'h05)
      else $error("40 MHz core ratio wrong");
   AST_STOP_RESTORE: assert property (I_STOP_EXIT |=> core_clk_divider == 2'h3)
      else $error("core divider not restored after stop exit");
   AST_PER_DIV16: assert property (periph_bus_divider == 3'h7 |-> per_ratio == 5'h10)
      else $error("peripheral bus ratio wrong");
   AST_SYS_DIV12: assert property (sys_bus_divider == 4'hB |-> sys_ratio == 5'h0C)
      else $error("system bus ratio wrong");
   AST_CORE_SPACING6: assert property (core_tick && core_held == 5'h06 && core_ratio == 5'h06
         |=> !core_tick [*5] ##1 core_tick)
      else $error("core enable spacing wrong at divide by six");

   // Bus dividers at ratio two; the second tick still depends on the upstream tick
   AST_SYS_SPACING2: assert property (sys_tick && sys_held == 5'h02 && sys_ratio == 5'h02
         && core_held == 5'h01 && core_ratio == 5'h01
         |=> !sys_tick ##1 (sys_tick == core_tick))
      else $error("system bus enable spacing wrong at divide by two");
   AST_PER_SPACING2: assert property (per_tick && per_held == 5'h02 && per_ratio == 5'h02
         && sys_held == 5'h01 && sys_ratio == 5'h01 && core_held == 5'h01 && core_ratio == 5'h01
         |=> !per_tick ##1 (per_tick == sys_tick))
      else $error("peripheral bus enable spacing wrong at divide by two");

   // Bus handshake: exactly one wait state, one accepting cycle, data only then
   AST_WAIT_ONE: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
      else $error("waitrequest did not fall after one wait state");
   AST_WAIT_BACK: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
      else $error("waitrequest stayed low past the accepting cycle");
   AST_RDATA_IDLE: assert property (O_AVS_WAITREQUEST |-> O_AVS_READDATA == 32'h0000_0000)
      else $error("read data not zero outside the accepting cycle");

   // Interrupt level tracks the masked sticky status
   AST_IRQ_LEVEL: assert property (O_IRQ == |(irq_status & irq_mask))
      else $error("interrupt level disagrees with masked status");
endmodule : ctp_clock_cfg

// File: tb/tb_ctp_clock_cfg.sv
// Self-checking bench for the clock trim, prescaler and clock-output block
`timescale 1ns/1ps
module tb_ctp_clock_cfg;
   // Driven inputs, all given a value at time zero
   logic        I_CLK            = 1'b0;
   logic        I_ARST_N         = 1'b0;
   logic [7:0]  I_AVS_ADDRESS    = 8'h00;
   logic        I_AVS_READ       = 1'b0;
   logic        I_AVS_WRITE      = 1'b0;
   logic [31:0] I_AVS_WRITEDATA  = 32'h0000_0000;
   logic [3:0]  I_AVS_BYTEENABLE = 4'hF;
   logic        I_OSC48_STABLE   = 1'b0;
   logic        I_OSC40_STABLE   = 1'b0;
   logic        I_OSC_IS_48      = 1'b1;
   logic        I_STOP_EXIT      = 1'b0;
   logic        I_SLOW_INT_EDGE  = 1'b0;
   logic        I_SLOW_EXT_EDGE  = 1'b0;
   // Observed outputs
   logic [31:0] O_AVS_READDATA;
   logic        O_AVS_WAITREQUEST;
   logic        O_CORE_CLK_EN;
   logic        O_SYS_BUS_CLK_EN;
   logic        O_PERIPH_CLK_EN;
   logic        O_CLKOUT;
   logic        O_IRQ;
   // Bookkeeping
   int          miscompares = 0;
   int          checked     = 0;
   int          cycles      = 0;
   int          sys_tab[16] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 4, 8, 12, 16, 24, 24, 24};
   int          per_tab[8]  = '{1, 1, 1, 1, 2, 4, 8, 16};

   ctp_clock_cfg uut (
      .I_CLK            (I_CLK),
      .I_ARST_N         (I_ARST_N),
      .I_AVS_ADDRESS    (I_AVS_ADDRESS),
      .I_AVS_READ       (I_AVS_READ),
      .I_AVS_WRITE      (I_AVS_WRITE),
      .I_AVS_WRITEDATA  (I_AVS_WRITEDATA),
      .I_AVS_BYTEENABLE (I_AVS_BYTEENABLE),
      .O_AVS_READDATA   (O_AVS_READDATA),
      .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
      .I_OSC48_STABLE   (I_OSC48_STABLE),
      .I_OSC40_STABLE   (I_OSC40_STABLE),
      .I_OSC_IS_48      (I_OSC_IS_48),
      .I_STOP_EXIT      (I_STOP_EXIT),
      .I_SLOW_INT_EDGE  (I_SLOW_INT_EDGE),
      .I_SLOW_EXT_EDGE  (I_SLOW_EXT_EDGE),
      .O_CORE_CLK_EN    (O_CORE_CLK_EN),
      .O_SYS_BUS_CLK_EN (O_SYS_BUS_CLK_EN),
      .O_PERIPH_CLK_EN  (O_PERIPH_CLK_EN),
      .O_CLKOUT         (O_CLKOUT),
      .O_IRQ            (O_IRQ)
   );

   // 50 MHz clock
   always #10 I_CLK = ~I_CLK;

   // Watchdog, a hang must not hide behind a silent run
   always @(posedge I_CLK)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Configuration word: clkout div, source, core, periph, sys bus; reserved bits zero
   function automatic logic [31:0] cfgw(input logic [1:0] core, input logic [2:0] per, input logic [3:0] sys,
                                        input logic [3:0] div, input logic [1:0] src);
      return {div, 1'b0, src, 11'h000, core, 1'b0, per, sys, 4'h0};
   endfunction : cfgw

   // One Avalon access; held until waitrequest is seen low, no cycle count assumed
   task automatic av(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be,
                     output logic [31:0] rd);
      @(posedge I_CLK);
      I_AVS_ADDRESS    <= addr;
      I_AVS_WRITEDATA  <= data;
      I_AVS_BYTEENABLE <= be;
      I_AVS_WRITE      <= wr;
      I_AVS_READ       <= ~wr;
      do
         @(posedge I_CLK);
      while (O_AVS_WAITREQUEST !== 1'b0);
      rd = O_AVS_READDATA;
      I_AVS_WRITE <= 1'b0;
      I_AVS_READ  <= 1'b0;
   endtask : av

   function automatic logic en_of(input int sel);
      return (sel == 0) ? O_CORE_CLK_EN : (sel == 1) ? O_SYS_BUS_CLK_EN : O_PERIPH_CLK_EN;
   endfunction : en_of

   // Pulse spacing after settling; early periods may still carry the old ratio
   task automatic meas(input int sel, input int exp_n, input string what);
      int k;
      int n;
      n = 0;
      for (k = 0; k < 4; k++)
      begin
         n = 0;
         do
         begin
            @(posedge I_CLK);
            n++;
         end
         while (en_of(sel) !== 1'b1 && n < 400);
      end
      check(what, n, exp_n);
   endtask : meas

   task automatic reg_test;
      logic [31:0] rd;
      av(1'b0, ctp_pkg::OFS_OSC_TRIM, 32'h0000_0000, 4'hF, rd);
      check("trim reset", rd, 32'h0000_0080);
      av(1'b0, ctp_pkg::OFS_CLK_CFG, 32'h0000_0000, 4'hF, rd);
      check("cfg reset", rd, 32'h2000_3000);
      av(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF, rd);
      av(1'b0, 8'h08, 32'h0000_0000, 4'hF, rd);
      check("unmapped", rd, 32'h0000_0000);
      av(1'b1, ctp_pkg::OFS_OSC_TRIM, 32'hFFFF_FFFF, 4'hF, rd);
      av(1'b0, ctp_pkg::OFS_OSC_TRIM, 32'h0000_0000, 4'hF, rd);
      check("trim write", rd, 32'h0000_00F0);
      av(1'b1, ctp_pkg::OFS_CLK_CFG, 32'hFFFF_FFFF, 4'h1, rd);
      av(1'b0, ctp_pkg::OFS_CLK_CFG, 32'h0000_0000, 4'hF, rd);
      check("cfg lane0", rd, 32'h2000_30F0);
      av(1'b1, ctp_pkg::OFS_CLK_CFG, 32'hF9FF_FFFF, 4'hF, rd);
      av(1'b0, ctp_pkg::OFS_CLK_CFG, 32'h0000_0000, 4'hF, rd);
      check("cfg reserved", rd, 32'hF000_37F0);
   endtask : reg_test

   // Ready flags, status events, mask and read-clear
   task automatic irq_test;
      logic [31:0] rd;
      av(1'b1, ctp_pkg::OFS_IRQ_MASK, 32'h0000_0001, 4'hF, rd);
      I_OSC48_STABLE <= 1'b1;
      repeat (4) @(posedge I_CLK);
      check("irq raised", O_IRQ, 32'h0000_0001);
      av(1'b0, ctp_pkg::OFS_IRQ_STATUS, 32'h0000_0000, 4'hF, rd);
      check("status 48", rd, 32'h0000_0001);
      repeat (3) @(posedge I_CLK);
      check("irq cleared", O_IRQ, 32'h0000_0000);
      I_OSC40_STABLE <= 1'b1;
      repeat (4) @(posedge I_CLK);
      check("irq masked", O_IRQ, 32'h0000_0000);
      av(1'b0, ctp_pkg::OFS_IRQ_STATUS, 32'h0000_0000, 4'hF, rd);
      check("status 40", rd, 32'h0000_0002);
      av(1'b0, ctp_pkg::OFS_OSC_TRIM, 32'h0000_0000, 4'hF, rd);
      check("ready flags", rd, 32'h0000_00F3);
   endtask : irq_test

   task automatic core_test;
      logic [31:0] rd;
      int c;
      for (c = 0; c < 4; c++)
      begin
         av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(c[1:0], 3'h0, 4'h0, 4'h2, 2'h0), 4'hF, rd);
         meas(0, (c == 0) ? 1 : (c == 1) ? 2 : 6, "core 48");
      end
      I_OSC_IS_48 <= 1'b0;
      for (c = 0; c < 4; c++)
      begin
         av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(c[1:0], 3'h0, 4'h0, 4'h2, 2'h0), 4'hF, rd);
         meas(0, (c == 0) ? 1 : 5, "core 40");
      end
      I_OSC_IS_48 <= 1'b1;
   endtask : core_test

   task automatic bus_test;
      logic [31:0] rd;
      int c;
      for (c = 0; c < 16; c++)
      begin
         av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(2'h0, 3'h0, c[3:0], 4'h2, 2'h0), 4'hF, rd);
         meas(1, sys_tab[c], "sys bus");
      end
      for (c = 0; c < 8; c++)
      begin
         av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(2'h0, c[2:0], 4'h0, 4'h2, 2'h0), 4'hF, rd);
         meas(2, per_tab[c], "periph");
      end
      // Divided core feeding divided buses: six times two, and twice that for the peripheral bus
      av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(2'h3, 3'h4, 4'h8, 4'h2, 2'h0), 4'hF, rd);
      meas(1, 12, "sys of core");
      meas(2, 24, "periph of sys");
   endtask : bus_test

   // Leaving deep stop forces the core field back to its reset code
   task automatic stop_test;
      logic [31:0] rd;
      av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(2'h0, 3'h0, 4'h0, 4'h2, 2'h0), 4'hF, rd);
      I_STOP_EXIT <= 1'b1;
      @(posedge I_CLK);
      I_STOP_EXIT <= 1'b0;
      av(1'b0, ctp_pkg::OFS_CLK_CFG, 32'h0000_0000, 4'hF, rd);
      check("stop exit cfg", rd, 32'h2000_3000);
      meas(0, 6, "core after stop");
   endtask : stop_test

   // Clock-output pin measured in slow edges; first two rises skipped as they may be truncated
   task automatic clkout_run(input logic [1:0] src, input logic [3:0] code, input int n_exp);
      logic [31:0] rd;
      logic        prev;
      int          k;
      int          last;
      int          rises;
      int          hi;
      av(1'b1, ctp_pkg::OFS_CLK_CFG, cfgw(2'h0, 3'h0, 4'h0, code, src), 4'hF, rd);
      prev  = O_CLKOUT;
      last  = 0;
      rises = 0;
      hi    = 0;
      // Room for the old period, up to 64 edges, to run out first
      for (k = 0; k < 8 * n_exp + 72; k++)
      begin
         @(posedge I_CLK);
         if (src == 2'h2)
            I_SLOW_EXT_EDGE <= 1'b1;
         else
            I_SLOW_INT_EDGE <= 1'b1;
         @(posedge I_CLK);
         I_SLOW_EXT_EDGE <= 1'b0;
         I_SLOW_INT_EDGE <= 1'b0;
         repeat (2) @(posedge I_CLK);
         if (O_CLKOUT === 1'b1 && prev !== 1'b1)
         begin
            if (rises >= 2)
            begin
               check("clkout period", k - last, 2 * n_exp);
               check("clkout high", hi, n_exp);
            end
            last = k;
            rises++;
            hi = 0;
         end
         hi += (O_CLKOUT === 1'b1) ? 1 : 0;
         prev = O_CLKOUT;
      end
      if (src == 2'h0)
         check("clkout idle", rises, 0);
      else
         check("clkout running", rises > 2, 1);
   endtask : clkout_run

   // Main sequence
   initial
   begin
      repeat (4) @(posedge I_CLK);
      I_ARST_N <= 1'b1;
      reg_test();
      irq_test();
      core_test();
      bus_test();
      stop_test();
      clkout_run(2'h1, 4'h0, 1);
      clkout_run(2'h1, 4'h1, 2);
      clkout_run(2'h1, 4'hE, 15);
      clkout_run(2'h1, 4'hF, 32);
      clkout_run(2'h2, 4'h2, 3);
      clkout_run(2'h0, 4'h0, 1);
      give_verdict();
   end
endmodule : tb_ctp_clock_cfg
